// ===== flash_poll_consts.vh
`ifndef FLASH_POLL_CONSTS_VH
`define FLASH_POLL_CONSTS_VH
// software port map (word index on i_addr)
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
// control word: [2:0] command, writing starts it
`define CMD_READ 3'h1
`define CMD_PROGRAM 3'h2
`define CMD_CHIP_ERASE 3'h3
`define CMD_SECTOR_ERASE 3'h4
`define CMD_RESET 3'h5
`define CMD_SUSPEND 3'h6
`define CMD_RESUME 3'h7
// status bits
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_RYBY 3
`define ST_ERASE_STARTED 4
`define ST_STALE 5
// status bit positions on the data bus
`define DQ_POLL 7
`define DQ_TOGGLE 6
`define DQ_TIMEOUT 5
`define DQ_ERASE_STARTED 3
`define DQ_TOGGLE2 2
// flash command bytes
`define FL_UNLOCK_A1 11'h555
`define FL_UNLOCK_D1 8'hAA
`define FL_UNLOCK_A2 11'h2AA
`define FL_UNLOCK_D2 8'h55
`define FL_PROG_BYTE 8'hA0
`define FL_ERASE_SETUP 8'h80
`define FL_CHIP_ERASE 8'h10
`define FL_SECTOR_ERASE 8'h30
`define FL_RESET_BYTE 8'hF0
`define FL_SUSPEND_BYTE 8'hB0
`define FL_RESUME_BYTE 8'h30
// bus cycle timing
`define T_CYCLE_NS 120
`define CLK_NS 40
`define CYC_PHASE ((`T_CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== flash_bus_cycle.v
`timescale 1ns/1ns
`default_nettype none
`include "flash_poll_consts.vh"
// one strobed bus cycle: setup, strobe low, strobe high, data sampled at strobe end
module flash_bus_cycle #(
    parameter AW = 18,
    parameter PHASE = `CYC_PHASE
) (
    input wire i_sys_clk,            // clock
    input wire i_rst_n,              // sync reset
    input wire i_start,              // begin a cycle
    input wire i_write,              // 1 write, 0 read
    input wire [AW-1:0] i_addr,      // address
    input wire [7:0] i_wdata,        // write byte
    input wire [7:0] i_dq_sync,      // synchronised dq
    output reg o_done,               // cycle over pulse
    output reg [7:0] o_rdata,        // sampled byte
    output reg [AW-1:0] o_a,         // flash address
    output reg [7:0] o_dq_out,       // dq drive value
    output reg o_dq_oe_n,            // dq enable, low drives
    output reg o_ce_n,               // chip select
    output reg o_oe_n,               // output enable
    output reg o_we_n                // write strobe
);
    localparam S_IDLE = 2'd0;
    localparam S_SETUP = 2'd1;
    localparam S_STROBE = 2'd2;
    localparam S_HOLD = 2'd3;
    reg [1:0] state;
    reg [7:0] cnt;
    reg wr;
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state <= S_IDLE;
            cnt <= 8'h00;
            wr <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 8'h00;
            o_a <= {AW{1'b0}};
            o_dq_out <= 8'h00;
            o_dq_oe_n <= 1'b1;
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
        end else begin
            o_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (i_start) begin
                        wr <= i_write;
                        o_a <= i_addr;
                        o_dq_out <= i_wdata;
                        o_dq_oe_n <= ~i_write;
                        o_ce_n <= 1'b0;
                        cnt <= 8'h00;
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    o_we_n <= ~wr;
                    o_oe_n <= wr;
                    state <= S_STROBE;
                end
                S_STROBE: begin
                    // dq passes three flops and the agreement register, so wait two extra cycles before sampling
                    if (cnt == PHASE[7:0] + 8'h02) begin
                        o_rdata <= i_dq_sync;
                        o_we_n <= 1'b1;
                        o_oe_n <= 1'b1;
                        cnt <= 8'h00;
                        state <= S_HOLD;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                S_HOLD: begin
                    if (cnt == PHASE[7:0]) begin
                        o_ce_n <= 1'b1;
                        o_dq_oe_n <= 1'b1;
                        o_done <= 1'b1;
                        state <= S_IDLE;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== flash_poll_host.v
// How it works
// RULE_01: while programming, bit 7 reads inverse of target bit 7.
// RULE_02: after programming, bit 7 reads true programmed value.
// RULE_03: program polling is valid after the fourth write pulse.
// RULE_04: erase reads 0 on bit 7, then 1 once finished.
// RULE_05: erase polling is valid after the sixth write pulse.
// RULE_06: host polls at the address being programmed or erased.
// RULE_07: bit 7 may turn valid before bits 0 to 6.
// RULE_08: after completion is seen, host reads once more for data.
// RULE_09: ready/busy pin is low while program or erase runs.
// RULE_10: ready/busy valid after final write pulse of sequence.
// RULE_11: bit 6 inverts on each read during an operation.
// RULE_12: bit 6 stops toggling once the operation completes.
// RULE_13: toggle bit valid after fourth (program) or sixth (erase) pulse.
// RULE_14: protected program target toggles about 2 us then stops.
// RULE_15: all-protected erase toggles about 100 us then read mode.
// RULE_16: bit 5 high means pulse count limit exceeded, failure.
// RULE_17: after bit 5 high, host rechecks whether bit 6 toggles.
// RULE_18: programming 0 to 1 halts; bit 5 rises after time limit.
// RULE_19: after timeout failure, host writes the reset command.
// RULE_20: sector erase sets bit 3 from 0 to 1 when started.
// RULE_21: bit 3 reads 1 right after the first 30h byte.
// RULE_22: bit 2 toggles on reads within sectors selected for erase.
// RULE_23: bit 6 holds constant after completion or suspend.
// RULE_24: idle device returns plain array data on every bit.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "flash_poll_consts.vh"
module flash_poll_host #(
    parameter AW = 18
) (
    input wire i_sys_clk,            // 25 MHz clock
    input wire i_rst_n,              // sync reset, active low
    input wire [3:0] i_addr,         // register index
    input wire [31:0] i_wdata,       // register write data
    input wire i_wr,                 // write strobe
    input wire i_rd,                 // read strobe
    output reg [31:0] o_rdata,       // read data, cycle after i_rd
    output wire [AW-1:0] o_flash_a,  // flash address
    input wire [7:0] i_dq,           // dq pins in
    output wire [7:0] o_dq,          // dq pins out
    output wire o_dq_oe_n,           // dq drive enable, low drives
    output wire o_ce_n,              // chip select
    output wire o_oe_n,              // output enable
    output wire o_we_n,              // write strobe
    input wire i_ready_busy_n_pin    // ready/busy pin level
);
    localparam F_IDLE = 3'd0;
    localparam F_SEQ = 3'd1;
    localparam F_POLL1 = 3'd2;
    localparam F_POLL2 = 3'd3;
    localparam F_FINAL = 3'd4;
    localparam F_RESET = 3'd5;

    reg [2:0] fstate;
    reg [2:0] cmd;
    reg [AW-1:0] target;
    reg [7:0] data;
    reg busy, done, fail, erase_started, stale;
    reg [2:0] step;
    reg [7:0] first_read, last_read;
    reg saw_timeout;
    reg start, cyc_write;
    reg [AW-1:0] cyc_addr;
    reg [7:0] cyc_data;
    wire cyc_done;
    wire [7:0] cyc_rdata;

    // three-flop input path, change accepted once last two agree
    reg [7:0] dq_s1, dq_s2, dq_s3, dq_sync;
    reg rb_s1, rb_s2, rb_s3, rb_sync;
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            dq_s1 <= 8'h00; dq_s2 <= 8'h00; dq_s3 <= 8'h00; dq_sync <= 8'h00;
            rb_s1 <= 1'b1; rb_s2 <= 1'b1; rb_s3 <= 1'b1; rb_sync <= 1'b1;
        end else begin
            dq_s1 <= i_dq; dq_s2 <= dq_s1; dq_s3 <= dq_s2;
            rb_s1 <= i_ready_busy_n_pin; rb_s2 <= rb_s1; rb_s3 <= rb_s2;
            if (dq_s2 == dq_s3) dq_sync <= dq_s3;
            if (rb_s2 == rb_s3) rb_sync <= rb_s3;
        end
    end

    flash_bus_cycle #(.AW(AW)) u_cycle (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_start(start),
        .i_write(cyc_write),
        .i_addr(cyc_addr),
        .i_wdata(cyc_data),
        .i_dq_sync(dq_sync),
        .o_done(cyc_done),
        .o_rdata(cyc_rdata),
        .o_a(o_flash_a),
        .o_dq_out(o_dq),
        .o_dq_oe_n(o_dq_oe_n),
        .o_ce_n(o_ce_n),
        .o_oe_n(o_oe_n),
        .o_we_n(o_we_n)
    );

    wire is_erase = (cmd == `CMD_CHIP_ERASE) || (cmd == `CMD_SECTOR_ERASE);
    // sequence length: four writes for program, six for erase, one otherwise
    wire [2:0] seq_len = (cmd == `CMD_PROGRAM) ? 3'd4 : (is_erase ? 3'd6 : 3'd1);

    // write k+1 is staged while write k runs, so start and address move together
    wire [AW-1:0] unlock_a1 = {{(AW-11){1'b0}}, `FL_UNLOCK_A1};
    wire [AW-1:0] unlock_a2 = {{(AW-11){1'b0}}, `FL_UNLOCK_A2};
    wire [2:0] seq_idx = step + 3'd1;
    // one-write commands carry their own byte in place of the first unlock byte
    wire [7:0] first_d = (i_wdata[2:0] == `CMD_RESET) ? `FL_RESET_BYTE :
        (i_wdata[2:0] == `CMD_SUSPEND) ? `FL_SUSPEND_BYTE :
        (i_wdata[2:0] == `CMD_RESUME) ? `FL_RESUME_BYTE : `FL_UNLOCK_D1;
    reg [AW-1:0] seq_a;
    reg [7:0] seq_d;
    always @* begin
        seq_a = target;
        seq_d = data;
        case (seq_idx)
            3'd1, 3'd4: begin
                seq_a = unlock_a2;
                seq_d = `FL_UNLOCK_D2;
            end
            3'd2: begin
                seq_a = unlock_a1;
                seq_d = is_erase ? `FL_ERASE_SETUP : `FL_PROG_BYTE;
            end
            3'd3: begin
                seq_a = is_erase ? unlock_a1 : target;
                seq_d = is_erase ? `FL_UNLOCK_D1 : data;
            end
            3'd5: begin
                seq_a = (cmd == `CMD_CHIP_ERASE) ? unlock_a1 : target;
                seq_d = (cmd == `CMD_CHIP_ERASE) ? `FL_CHIP_ERASE : `FL_SECTOR_ERASE;
            end
            default: begin
                seq_a = target;
                seq_d = data;
            end
        endcase
    end

    // operation finished when bit 7 shows final value
    wire poll_done = is_erase ? cyc_rdata[`DQ_POLL] : (cyc_rdata[`DQ_POLL] == data[`DQ_POLL]); // RULE_01 RULE_02
    wire toggling = (cyc_rdata[`DQ_TOGGLE] != first_read[`DQ_TOGGLE]); // RULE_11 RULE_12 RULE_23

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            fstate <= F_IDLE;
            cmd <= 3'h0;
            target <= {AW{1'b0}};
            data <= 8'h00;
            busy <= 1'b0; done <= 1'b0; fail <= 1'b0;
            erase_started <= 1'b0; stale <= 1'b0; saw_timeout <= 1'b0;
            step <= 3'd0;
            first_read <= 8'h00; last_read <= 8'h00;
            start <= 1'b0; cyc_write <= 1'b0;
            cyc_addr <= {AW{1'b0}}; cyc_data <= 8'h00;
        end else begin
            start <= 1'b0;
            if (i_wr && i_addr == `REG_ADDR && !busy) target <= i_wdata[AW-1:0];
            if (i_wr && i_addr == `REG_DATA && !busy) data <= i_wdata[7:0];
            case (fstate)
                F_IDLE: begin
                    if (i_wr && i_addr == `REG_CTRL && i_wdata[2:0] != 3'h0) begin
                        cmd <= i_wdata[2:0];
                        busy <= 1'b1; done <= 1'b0; fail <= 1'b0;
                        stale <= 1'b0; saw_timeout <= 1'b0; step <= 3'd0;
                        if (i_wdata[2:0] != `CMD_SUSPEND) erase_started <= 1'b0;
                        fstate <= (i_wdata[2:0] == `CMD_READ) ? F_FINAL : F_SEQ;
                        start <= 1'b1;
                        cyc_write <= (i_wdata[2:0] != `CMD_READ);
                        cyc_addr <= (i_wdata[2:0] == `CMD_READ) ? target : unlock_a1;
                        cyc_data <= first_d;
                    end
                end
                F_SEQ: begin
                    if (cyc_done) begin
                        if (step + 3'd1 == seq_len) begin
                            // polling begins only after the last write pulse
                            if (cmd == `CMD_PROGRAM || is_erase) begin // RULE_03 RULE_05 RULE_10 RULE_13
                                fstate <= F_POLL1;
                                start <= 1'b1;
                                cyc_write <= 1'b0;
                                cyc_addr <= target; // RULE_06
                            end else begin
                                busy <= 1'b0;
                                done <= 1'b1;
                                fstate <= F_IDLE;
                            end
                        end else begin
                            step <= step + 3'd1;
                            start <= 1'b1;
                        end
                    end else begin
                        cyc_addr <= seq_a;
                        cyc_data <= seq_d;
                    end
                end
                F_POLL1: begin
                    if (cyc_done) begin
                        first_read <= cyc_rdata;
                        if (cyc_rdata[`DQ_ERASE_STARTED] && cmd == `CMD_SECTOR_ERASE)
                            erase_started <= 1'b1; // RULE_20 RULE_21
                        fstate <= F_POLL2;
                        start <= 1'b1;
                    end
                end
                F_POLL2: begin
                    if (cyc_done) begin
                        last_read <= cyc_rdata;
                        if (poll_done || !toggling) begin
                            // bits 0..6 may lag bit 7: fetch a clean copy
                            fstate <= F_FINAL; // RULE_07 RULE_08
                            start <= 1'b1;
                        end else if (saw_timeout) begin
                            fail <= 1'b1; // RULE_16 RULE_18
                            fstate <= F_RESET;
                            cmd <= `CMD_RESET;
                            step <= 3'd0;
                            start <= 1'b1;
                            cyc_write <= 1'b1;
                            cyc_addr <= unlock_a1;
                            cyc_data <= `FL_RESET_BYTE; // RULE_19
                        end else begin
                            // still toggling: recheck once more after a bit-5 sighting
                            saw_timeout <= cyc_rdata[`DQ_TIMEOUT]; // RULE_17
                            first_read <= cyc_rdata;
                            start <= 1'b1;
                        end
                    end
                end
                F_FINAL: begin
                    if (cyc_done) begin
                        last_read <= cyc_rdata; // RULE_24
                        // a protected target ends without changing data
                        stale <= (cmd == `CMD_PROGRAM) && (cyc_rdata != data); // RULE_14 RULE_15
                        busy <= 1'b0;
                        done <= 1'b1;
                        fstate <= F_IDLE;
                    end
                end
                F_RESET: begin
                    if (cyc_done) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        fstate <= F_IDLE;
                    end
                end
                default: fstate <= F_IDLE;
            endcase
        end
    end

    // register reads; low ready/busy reported as-is for software
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                `REG_CTRL: o_rdata <= {29'h00000000, cmd};
                `REG_ADDR: o_rdata <= {{(32-AW){1'b0}}, target};
                `REG_DATA: o_rdata <= {24'h000000, data};
                `REG_STATUS: o_rdata <= {26'h0000000, stale, erase_started, rb_sync, fail, done, busy}; // RULE_09
                `REG_RDATA: o_rdata <= {16'h0000, first_read, last_read}; // RULE_22
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ===== flash_poll_host_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module flash_poll_host_monitor #(parameter AW = 18) (
    input wire logic i_sys_clk, // clock
    input wire logic i_rst_n, // reset
    input wire logic [3:0] i_addr, // reg index
    input wire logic [31:0] i_wdata, // reg data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    input wire logic [31:0] o_rdata, // read data
    input wire logic [AW-1:0] o_flash_a, // flash address
    input wire logic [7:0] i_dq, // dq in
    input wire logic [7:0] o_dq, // dq out
    input wire logic o_dq_oe_n, // dq enable
    input wire logic o_ce_n, // chip select
    input wire logic o_oe_n, // output enable
    input wire logic o_we_n, // write strobe
    input wire logic i_ready_busy_n_pin // ready pin
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_pulse;
        !o_we_n [*6] ##1 o_we_n;
    endsequence
    sequence s_rd_pulse;
        !o_oe_n [*6] ##1 o_oe_n;
    endsequence
    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_wr_width: assert property ($fell(o_we_n) |-> s_wr_pulse)
        else $error("write pulse width wrong");
    a_rd_width: assert property ($fell(o_oe_n) |-> s_rd_pulse)
        else $error("read pulse width wrong");
    a_strobe_excl: assert property (!(!o_we_n && !o_oe_n))
        else $error("both strobes low");
    a_ce_setup: assert property ($fell(o_we_n) || $fell(o_oe_n) |-> !$past(o_ce_n))
        else $error("strobe without select setup");
    a_wr_drives: assert property (!o_we_n |-> !o_dq_oe_n && !o_ce_n)
        else $error("write strobe without drive");
    a_rd_floats: assert property (!o_oe_n |-> o_dq_oe_n && !o_ce_n)
        else $error("host drives during read");
    a_wr_hold: assert property (!o_we_n && !$past(o_we_n) |-> $stable(o_flash_a) && $stable(o_dq))
        else $error("address or data moved in pulse");
    a_ce_release: assert property ($rose(o_we_n) |-> !o_ce_n ##[1:8] o_ce_n)
        else $error("select not released after write");
    a_unmapped_zero: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind flash_poll_host flash_poll_host_monitor #(.AW(AW)) u_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_a(o_flash_a),
    .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .i_ready_busy_n_pin(i_ready_busy_n_pin));
`default_nettype wire

// ===== flash_status_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_status_model #(parameter AW = 18, parameter PROG_CYC = 200, parameter ERASE_CYC = 400,
    parameter LIMIT_CYC = 600) (
    input wire logic i_clk, // model time base
    input wire logic [AW-1:0] i_a, // address
    input wire logic [7:0] i_dq_host, // host drive value
    input wire logic i_dq_oe_n, // host drives when low
    input wire logic i_ce_n, // chip select
    input wire logic i_oe_n, // output enable
    input wire logic i_we_n, // write strobe
    output wire logic [7:0] o_dq, // resolved bus
    output wire logic o_rb_low, // open drain pulls low
    output wire logic [31:0] o_bad_poll // polls off target
);
    logic [7:0] mem [0:255];
    logic [7:0] tdata = 8'h00, rd = 8'h00, last = 8'h00;
    logic [AW-1:0] taddr;
    logic pwe = 1'b1, poe = 1'b1, busy = 1'b0, fail = 1'b0, tog = 1'b0, tog2 = 1'b0;
    logic ers = 1'b0, sect = 1'b0, halt = 1'b0, prot = 1'b0;
    int step = 0, cnt = 0;
    int bad_cnt = 0;
    wire logic [7:0] d = i_dq_host;
    wire logic pg = step == 6;
    // protection: upper half of the address space
    wire logic pr = i_a[AW-1] && (pg || d == 8'h30);
    wire logic hv = pg && |(d & ~mem[i_a[7:0]]);
    // released bus shows a changing pattern so stale data never passes
    assign o_dq = !i_dq_oe_n ? i_dq_host : (!i_ce_n && !i_oe_n) ? rd : ~last;
    assign o_rb_low = busy;
    assign o_bad_poll = bad_cnt;
    initial begin
        for (int k = 0; k < 256; k++) mem[k] = 8'hFF;
    end
    always @(posedge i_clk) begin
        pwe <= i_we_n;
        poe <= i_oe_n;
        last <= o_dq;
        if (!i_ce_n && !i_oe_n && poe) begin
            if (busy) begin
                // one bus cycle before the end bit 7 turns final while bits 6..0 still lag
                if (cnt <= 12 && !halt && !prot)
                    rd <= {ers | tdata[7], 7'h00};
                else
                    rd <= {ers ? 1'b0 : ~tdata[7], tog, fail, 1'b0, ers & sect, ers & tog2, 2'b00};
                tog <= ~tog;
                tog2 <= ~tog2;
                if (!ers && i_a != taddr) bad_cnt <= bad_cnt + 1;
            end else begin
                rd <= mem[i_a[7:0]];
            end
        end
        if (!i_ce_n && i_we_n && !pwe) begin
            if (d == 8'hF0 && (!busy || fail)) begin
                busy <= 1'b0;
                fail <= 1'b0;
                step <= 0;
            end else if (!busy) begin
                step <= 0;
                case (step)
                    0: if (d == 8'hAA) step <= 1;
                    1: if (d == 8'h55) step <= 2;
                    2: step <= (d == 8'hA0) ? 6 : (d == 8'h80) ? 3 : 0;
                    3: if (d == 8'hAA) step <= 4;
                    4: if (d == 8'h55) step <= 5;
                    default: if (pg || d == 8'h10 || d == 8'h30) begin
                        busy <= 1'b1;
                        ers <= !pg;
                        sect <= d == 8'h30;
                        taddr <= i_a;
                        tdata <= d;
                        prot <= pr;
                        halt <= hv && !pr;
                        cnt <= pr ? (pg ? 50 : 2500) : hv ? LIMIT_CYC : pg ? PROG_CYC : ERASE_CYC;
                    end
                endcase
            end
        end
        if (busy && cnt == 1) begin
            if (halt) begin
                fail <= 1'b1;
            end else begin
                busy <= 1'b0;
                if (!prot && !ers) mem[taddr[7:0]] <= tdata;
                if (!prot && ers) for (int k = 0; k < 256; k++) mem[k] <= 8'hFF;
            end
        end
        if (cnt > 0) cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// ===== flash_poll_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_poll_consts.vh"
module flash_poll_host_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata, s;
    logic [17:0] o_flash_a;
    logic [7:0] o_dq, dq_bus;
    logic o_dq_oe_n, o_ce_n, o_oe_n, o_we_n, rb_low;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int bad_poll;
    // pull-up on the shared open-drain line
    wire logic rb_pin = rb_low ? 1'b0 : 1'b1;
    flash_poll_host #(.AW(18)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_a(o_flash_a), .i_dq(dq_bus),
        .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
        .i_ready_busy_n_pin(rb_pin));
    flash_status_model #(.AW(18)) u_flash (.i_clk(i_sys_clk), .i_a(o_flash_a), .i_dq_host(o_dq),
        .i_dq_oe_n(o_dq_oe_n), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .o_dq(dq_bus),
        .o_rb_low(rb_low), .o_bad_poll(bad_poll));
    always #20 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        comparisons++;
        if ((got & mask) !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got & mask, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // starts one command and polls status until the controller is idle
    task automatic run_op(input logic [17:0] fa, input logic [7:0] fd, input logic [2:0] cmd, input logic rb);
        int n;
        reg_wr(`REG_ADDR, {14'h0, fa});
        reg_wr(`REG_DATA, {24'h0, fd});
        reg_wr(`REG_CTRL, {29'h0, cmd});
        n = 0;
        if (rb) begin
            do begin reg_rd(`REG_STATUS, s); n++; end while (s[`ST_RYBY] !== 1'b0 && n < 400);
            chk(s, 32'h1, 32'h9);
        end
        n = 0;
        do begin reg_rd(`REG_STATUS, s); n++; end while (s[`ST_BUSY] !== 1'b0 && n < 5000);
    endtask
    task automatic read_back(input logic [17:0] fa, input logic [7:0] exp);
        run_op(fa, 8'h00, `CMD_READ, 1'b0);
        reg_rd(`REG_RDATA, s);
        chk(s, {24'h0, exp}, 32'hFF);
    endtask
    task automatic t_idle_read;
        reg_rd(4'hF, s);
        chk(s, 32'h0, 32'hFFFFFFFF);
        read_back(18'h00010, 8'hFF);
    endtask
    task automatic t_program;
        run_op(18'h00010, 8'h5A, `CMD_PROGRAM, 1'b1);
        chk(s, 32'h2, 32'h27);
        reg_rd(`REG_RDATA, s);
        chk(s, 32'h5A, 32'hFF);
        read_back(18'h00010, 8'h5A);
        chk(32'(bad_poll), 32'h0, 32'hFFFFFFFF);
    endtask
    task automatic t_overwrite;
        run_op(18'h00010, 8'hFF, `CMD_PROGRAM, 1'b1);
        chk(s, 32'h4, 32'h25);
        read_back(18'h00010, 8'h5A);
    endtask
    task automatic t_prot_prog;
        run_op(18'h20010, 8'h00, `CMD_PROGRAM, 1'b1);
        chk(s, 32'h20, 32'h25);
        read_back(18'h20010, 8'h5A);
    endtask
    task automatic t_sector_erase;
        run_op(18'h00010, 8'h00, `CMD_SECTOR_ERASE, 1'b1);
        chk(s, 32'h10, 32'h15);
        read_back(18'h00010, 8'hFF);
    endtask
    task automatic t_chip_erase;
        run_op(18'h00020, 8'h33, `CMD_PROGRAM, 1'b1);
        run_op(18'h00000, 8'h00, `CMD_CHIP_ERASE, 1'b1);
        chk(s, 32'h0, 32'h15);
        read_back(18'h00020, 8'hFF);
    endtask
    task automatic t_prot_erase;
        run_op(18'h00030, 8'h11, `CMD_PROGRAM, 1'b1);
        run_op(18'h20030, 8'h00, `CMD_SECTOR_ERASE, 1'b1);
        chk(s, 32'h0, 32'h5);
        read_back(18'h00030, 8'h11);
    endtask
    // single-write bytes leave the flash back at step 0, so the program that follows still starts
    task automatic t_single_cmds;
        for (int c = 5; c <= 7; c++) begin
            run_op(18'h00000, 8'h00, 3'(c), 1'b0);
            chk(s, 32'h2, 32'h7);
        end
        run_op(18'h00040, 8'h12, `CMD_PROGRAM, 1'b1);
        read_back(18'h00040, 8'h12);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            end_of_test;
        end
    end
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_idle_read;
        t_program;
        t_overwrite;
        t_prot_prog;
        t_sector_erase;
        t_chip_erase;
        t_prot_erase;
        t_single_cmds;
        end_of_test;
    end
endmodule
`default_nettype wire
